// [rtl/pps_defines.svh]
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ----------------------------------------------------------------------
// sizes of the routing matrix
// ----------------------------------------------------------------------
`define PPS_NUM_PINS      22          // remappable pins, numbered 0..21
`define PPS_NUM_INPUTS    18          // routable peripheral inputs
`define PPS_SEL_W         5           // width of every selector field
`define PPS_PERIPH_W      32          // one peripheral output per code
`define PPS_LAST_PIN      5'h15       // highest pin number present

// ----------------------------------------------------------------------
// reset values of the selectors
// ----------------------------------------------------------------------
`define PPS_IN_SEL_RST    5'h1f       // inputs point at absent pin 31
`define PPS_OUT_SEL_RST   5'h00       // outputs take the null function
`define PPS_LOCK_RST      1'b0        // map starts out unlocked

// ----------------------------------------------------------------------
// unlock key bytes, written in this order
// ----------------------------------------------------------------------
`define PPS_KEY_FIRST     8'h55
`define PPS_KEY_SECOND    8'haa

// ----------------------------------------------------------------------
// index of each routable peripheral input
// ----------------------------------------------------------------------
`define PPS_IN_EXT_EXT_INTERRUPT_ONE   0
`define PPS_IN_EXT_INT2   1
`define PPS_IN_EXT_INT3   2
`define PPS_IN_T0_CLK     3
`define PPS_IN_T3_CLK     4
`define PPS_IN_T5_CLK     5
`define PPS_IN_CAPT1      6
`define PPS_IN_CAPT2      7
`define PPS_IN_CAPT3      8
`define PPS_IN_T1_GATE    9
`define PPS_IN_T3_GATE    10
`define PPS_IN_T5_GATE    11
`define PPS_IN_SER2_RX    12
`define PPS_IN_SER2_CLK   13
`define PPS_IN_SPI2_DATA  14
`define PPS_IN_SPI2_CLK   15
`define PPS_IN_SPI2_SEL   16
`define PPS_IN_PWM_FAULT  17

// level seen by an input routed to an absent pin (slave select idles high)
`define PPS_IN_IDLE       18'h1_0000

// ----------------------------------------------------------------------
// output function codes
// ----------------------------------------------------------------------
`define PPS_OUT_NULL      5'h00
`define PPS_OUT_CMP1      5'h01
`define PPS_OUT_CMP3      5'h03
`define PPS_OUT_SER2_TX   5'h06
`define PPS_OUT_SER2_DT   5'h07
`define PPS_OUT_SPI2_DO   5'h0a
`define PPS_OUT_SPI2_CK   5'h0b
`define PPS_OUT_SPI_SS    5'h0c
`define PPS_OUT_WAKE      5'h0d
`define PPS_OUT_PWM1_A    5'h0e
`define PPS_OUT_PWM1_D    5'h11
`define PPS_OUT_PWM2_A    5'h12
`define PPS_OUT_PWM2_D    5'h15
`define PPS_OUT_PWM3_A    5'h16
`define PPS_OUT_PWM3_D    5'h19

`endif

// [rtl/pps_in_mux.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"

module pps_in_mux (
	input  wire logic [`PPS_NUM_PINS-1:0]   i_pin_dig,  // digital pin levels
	input  wire pps_pkg::in_sel_vec_t       i_in_sel,   // one selector per input
	output logic      [`PPS_NUM_INPUTS-1:0] o_periph_in // routed peripheral inputs
);

	// ------------------------------------------------------------------
	// per-peripheral selection; one pin may feed many inputs
	// ------------------------------------------------------------------
	localparam logic [`PPS_NUM_INPUTS-1:0] IDLE_LEVEL = `PPS_IN_IDLE;

	genvar g;
	generate
		for (g = 0; g < `PPS_NUM_INPUTS; g++) begin : g_in
			wire logic present = pps_pkg::pin_is_present(i_in_sel[g]);
			// absent pins give the idle level, never an x from the array
			assign o_periph_in[g] = present ? i_pin_dig[i_in_sel[g]] : IDLE_LEVEL[g];
		end
	endgenerate

endmodule : pps_in_mux

`default_nettype wire

// [rtl/pps_out_mux.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"

module pps_out_mux (
	input  wire logic [`PPS_PERIPH_W-1:0] i_periph_out, // peripheral outputs by code
	input  wire pps_pkg::out_sel_vec_t    i_out_sel,    // one selector per pin
	output logic      [`PPS_NUM_PINS-1:0] o_route_val,  // routed level per pin
	output logic      [`PPS_NUM_PINS-1:0] o_route_act   // pin carries a routed output
);

	// ------------------------------------------------------------------
	// per-pin selection; one output may drive many pins
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PPS_NUM_PINS; g++) begin : g_out
			// null and unassigned codes leave the pin to its own logic
			assign o_route_act[g] = pps_pkg::code_is_defined(i_out_sel[g]);
			assign o_route_val[g] = o_route_act[g] & i_periph_out[i_out_sel[g]];
		end
	endgenerate

endmodule : pps_out_mux

`default_nettype wire

// [rtl/pps_pkg.sv]
`include "pps_defines.svh"

package pps_pkg;

	// ------------------------------------------------------------------
	// selector types
	// ------------------------------------------------------------------
	typedef logic [`PPS_SEL_W-1:0]                      sel_t;
	typedef logic [`PPS_NUM_INPUTS-1:0][`PPS_SEL_W-1:0] in_sel_vec_t;
	typedef logic [`PPS_NUM_PINS-1:0][`PPS_SEL_W-1:0]   out_sel_vec_t;

	// unlock sequence tracker, gray coded along idle -> first -> armed
	typedef enum logic [1:0] {
		KEY_IDLE  = 2'b00,
		KEY_FIRST = 2'b01,
		KEY_ARMED = 2'b11
	} key_state_e;

	// true for a code that names a real peripheral output
	function automatic logic code_is_defined(input sel_t code);
		code_is_defined = ((code >= `PPS_OUT_CMP1) && (code <= `PPS_OUT_CMP3)) ||
			((code >= `PPS_OUT_SER2_TX) && (code <= `PPS_OUT_SER2_DT)) ||
			((code >= `PPS_OUT_SPI2_DO) && (code <= `PPS_OUT_PWM3_D));
	endfunction : code_is_defined

	// true for a pin number present on this device
	function automatic logic pin_is_present(input sel_t pin);
		pin_is_present = (pin <= `PPS_LAST_PIN);
	endfunction : pin_is_present

endpackage : pps_pkg

// [rtl/remappable_peripheral_pin_select.sv]
// Contract
// - twenty-two remappable pins, any function anywhere
// - per-input 5-bit selector picks source pin
// - interrupt, timer clock, timer gate inputs routable
// - capture, serial two, spi two, fault routable
// - per-pin selector picks peripheral output
// - output code zero disconnects the pin
// - reset puts null function on every pin
// - codes 1-3 comparators, 13 wake event
// - codes 6,7 serial two transmit outputs
// - codes 10-12 spi data, clock, slave select
// - codes 14-17 first pwm unit A-D
// - codes 18-21 second pwm unit A-D
// - codes 22-25 third pwm unit A-D
// - routed output beats other digital pin functions
// - analog function always beats routed output
// - no default pin; software must assign one
// - fan-out allowed both for inputs and outputs
// - every mapping combination is accepted
// - lock set silently ignores selector writes
// - lock changes only right after 55h, AAh
// - fuse keeps lock set until reset
// - reset: inputs 11111, outputs 00000
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"

module remappable_peripheral_pin_select (
	input  wire logic                       i_clk,                 // 10 MHz clock
	input  wire logic                       i_sys_rst,             // sync reset, high
	input  wire logic                       i_single_session_fuse, // one write session
	input  wire logic                       i_key_wr,              // unlock key write
	input  wire logic [7:0]                 i_key_data,            // unlock key byte
	input  wire logic                       i_lock_wr,             // lock bit write
	input  wire logic                       i_lock_data,           // new lock value
	input  wire logic                       i_in_sel_wr,           // input selector write
	input  wire logic [`PPS_SEL_W-1:0]      i_in_sel_idx,          // which input
	input  wire logic                       i_out_sel_wr,          // output selector write
	input  wire logic [`PPS_SEL_W-1:0]      i_out_sel_idx,         // which pin
	input  wire logic [`PPS_SEL_W-1:0]      i_sel_data,            // selector value
	input  wire logic [`PPS_SEL_W-1:0]      i_rd_idx,              // readback index
	input  wire logic [`PPS_NUM_PINS-1:0]   i_pin_in,              // pin input levels
	input  wire logic [`PPS_NUM_PINS-1:0]   i_gpio_out,            // fixed function data
	input  wire logic [`PPS_NUM_PINS-1:0]   i_gpio_oe,             // fixed function enable
	input  wire logic [`PPS_NUM_PINS-1:0]   i_analog_en,           // pin in analog mode
	input  wire logic [`PPS_PERIPH_W-1:0]   i_periph_out,          // peripheral outs by code
	output logic      [`PPS_NUM_INPUTS-1:0] o_periph_in,           // routed peripheral inputs
	output logic      [`PPS_NUM_PINS-1:0]   o_pin_out,             // pin output level
	output logic      [`PPS_NUM_PINS-1:0]   o_pin_oe,              // pin driven when high
	output logic                            o_map_write_lock,      // lock state
	output logic                            o_unlock_armed,        // key sequence done
	output logic      [`PPS_SEL_W-1:0]      o_in_sel_rdata,        // input selector readback
	output logic      [`PPS_SEL_W-1:0]      o_out_sel_rdata        // output selector readback
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	pps_pkg::in_sel_vec_t  in_sel;         // input_route_selectors
	pps_pkg::out_sel_vec_t out_sel;        // output_route_selectors
	logic                  map_write_lock; // selector write protect
	pps_pkg::key_state_e   key_state;      // unlock sequence progress
	pps_pkg::key_state_e   next_key_state; // its next value

	// ------------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------------
	wire logic any_sel_wr  = i_in_sel_wr | i_out_sel_wr;
	wire logic key_first   = i_key_wr && (i_key_data == `PPS_KEY_FIRST);
	wire logic key_second  = i_key_wr && (i_key_data == `PPS_KEY_SECOND);
	wire logic armed       = (key_state == pps_pkg::KEY_ARMED);
	// any other access breaks a sequence that is under way
	wire logic key_break   = (i_key_wr && !key_first) || i_lock_wr || any_sel_wr;
	// a locked write still completes, it simply lands nowhere
	wire logic in_wr_ok    = i_in_sel_wr && !map_write_lock &&
		(i_in_sel_idx < 5'(`PPS_NUM_INPUTS));
	wire logic out_wr_ok   = i_out_sel_wr && !map_write_lock &&
		(i_out_sel_idx < 5'(`PPS_NUM_PINS));
	// the fuse forbids clearing a set lock; setting needs only the key sequence
	wire logic clear_block = i_single_session_fuse && map_write_lock && !i_lock_data;
	wire logic lock_take   = i_lock_wr && armed && !clear_block;

	// ------------------------------------------------------------------
	// unlock sequence: 55h then AAh, then the very next access
	// ------------------------------------------------------------------
	// a fresh 55h always restarts at step one, whatever came before
	always_comb begin
		next_key_state = key_state;
		case (key_state)
			pps_pkg::KEY_IDLE: begin
				if (key_first) begin
					next_key_state = pps_pkg::KEY_FIRST; // step one seen
				end
			end
			pps_pkg::KEY_FIRST: begin
				if (key_second) begin
					next_key_state = pps_pkg::KEY_ARMED;
				end else if (key_break) begin
					next_key_state = pps_pkg::KEY_IDLE; // wrong byte or access
				end
			end
			pps_pkg::KEY_ARMED: begin
				// the lock write consumes it; anything else breaks it
				if (key_first) begin
					next_key_state = pps_pkg::KEY_FIRST; // restart
				end else if (key_break) begin
					next_key_state = pps_pkg::KEY_IDLE;
				end
			end
			default: begin
				next_key_state = pps_pkg::KEY_IDLE; // stray code recovers
			end
		endcase
	end

	// key tracker register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			key_state <= pps_pkg::KEY_IDLE;
		end else begin
			key_state <= next_key_state;
		end
	end

	// ------------------------------------------------------------------
	// lock bit
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			map_write_lock <= `PPS_LOCK_RST;
		end else if (lock_take) begin
			map_write_lock <= i_lock_data;
		end
	end

	// ------------------------------------------------------------------
	// selector storage; no value is ever rejected
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			in_sel <= {`PPS_NUM_INPUTS{`PPS_IN_SEL_RST}};
		end else if (in_wr_ok) begin
			in_sel[i_in_sel_idx] <= i_sel_data;
		end
	end

	// output selectors start on null, so no peripheral output reaches a pin
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			out_sel <= {`PPS_NUM_PINS{`PPS_OUT_SEL_RST}};
		end else if (out_wr_ok) begin
			out_sel[i_out_sel_idx] <= i_sel_data;
		end
	end

	// ------------------------------------------------------------------
	// status and readback flops
	// ------------------------------------------------------------------
	wire logic [`PPS_SEL_W-1:0] in_rd  = (i_rd_idx < 5'(`PPS_NUM_INPUTS)) ?
		in_sel[i_rd_idx] : `PPS_SEL_W'(0);
	wire logic [`PPS_SEL_W-1:0] out_rd = (i_rd_idx < 5'(`PPS_NUM_PINS)) ?
		out_sel[i_rd_idx] : `PPS_SEL_W'(0);

	// readback lags the index by one edge
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_in_sel_rdata  <= `PPS_SEL_W'(0);
			o_out_sel_rdata <= `PPS_SEL_W'(0);
			o_unlock_armed  <= 1'b0;
		end else begin
			o_in_sel_rdata  <= in_rd;
			o_out_sel_rdata <= out_rd;
			o_unlock_armed  <= (next_key_state == pps_pkg::KEY_ARMED);
		end
	end

	assign o_map_write_lock = map_write_lock;

	// ------------------------------------------------------------------
	// routing; combinational so peripherals see pins with no delay
	// ------------------------------------------------------------------
	// analog pins read low digitally, the input buffer is off
	wire logic [`PPS_NUM_PINS-1:0] pin_dig = i_pin_in & ~i_analog_en;
	wire logic [`PPS_NUM_PINS-1:0] route_val; // routed level per pin
	wire logic [`PPS_NUM_PINS-1:0] route_act; // pin has a routed output

	// per-peripheral input selection
	pps_in_mux u_in_mux (
		.i_pin_dig   (pin_dig),
		.i_in_sel    (in_sel),
		.o_periph_in (o_periph_in)
	);

	// per-pin output selection, indexed by function code
	pps_out_mux u_out_mux (
		.i_periph_out (i_periph_out),
		.i_out_sel    (out_sel),
		.o_route_val  (route_val),
		.o_route_act  (route_act)
	);

	// priority per pin: analog, then routed output, then fixed logic
	wire logic [`PPS_NUM_PINS-1:0] route_win = route_act & ~i_analog_en;
	// each pin chooses by its own bit, never by the whole vector
	wire logic [`PPS_NUM_PINS-1:0] gpio_win  = ~route_act & ~i_analog_en; // fixed logic keeps it
	assign o_pin_out = (route_win & route_val) | (gpio_win & i_gpio_out);
	assign o_pin_oe  = route_win | (i_gpio_oe & ~i_analog_en);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking

	// helper masks: pins on null code, inputs aimed at absent pins
	logic [`PPS_NUM_PINS-1:0]   null_mask;
	logic [`PPS_NUM_INPUTS-1:0] absent_mask;
	always_comb begin
		for (int k = 0; k < `PPS_NUM_PINS; k++) begin
			null_mask[k] = (out_sel[k] == `PPS_OUT_NULL);
		end
		for (int k = 0; k < `PPS_NUM_INPUTS; k++) begin
			absent_mask[k] = !pps_pkg::pin_is_present(in_sel[k]);
		end
	end

	localparam logic [`PPS_NUM_INPUTS-1:0] IDLE_LEVEL = `PPS_IN_IDLE;

	sequence s_key_first;
		i_key_wr && (i_key_data == `PPS_KEY_FIRST);
	endsequence
	sequence s_key_second;
		i_key_wr && (i_key_data == `PPS_KEY_SECOND);
	endsequence
	sequence s_unlock_clear;
		i_lock_wr && !i_lock_data && !i_single_session_fuse;
	endsequence
	sequence s_lock_set;
		i_lock_wr && i_lock_data;
	endsequence

	chk_reset_values_held: assert property (
		i_sys_rst |=> (in_sel == {`PPS_NUM_INPUTS{`PPS_IN_SEL_RST}}) &&
			(out_sel == {`PPS_NUM_PINS{`PPS_OUT_SEL_RST}}) && !o_map_write_lock
	) else $error("selectors or lock wrong after reset");

	chk_lock_blocks_write: assert property (
		disable iff (i_sys_rst)
		(o_map_write_lock && any_sel_wr) |=> $stable(in_sel) && $stable(out_sel)
	) else $error("selector changed while locked");

	chk_open_write_lands: assert property (
		disable iff (i_sys_rst)
		(!o_map_write_lock && i_out_sel_wr && (i_out_sel_idx < 5'h16))
			|=> out_sel[$past(i_out_sel_idx)] == $past(i_sel_data)
	) else $error("unlocked output selector write lost");

	chk_unlock_seq_clear: assert property (
		disable iff (i_sys_rst)
		s_key_first ##1 s_key_second ##1 s_unlock_clear |=> !o_map_write_lock
	) else $error("lock not cleared after full key sequence");

	chk_lock_needs_key: assert property (
		disable iff (i_sys_rst)
		(i_lock_wr && (key_state != pps_pkg::KEY_ARMED)) |=> $stable(o_map_write_lock)
	) else $error("lock changed without key sequence");

	chk_fuse_keeps_lock: assert property (
		disable iff (i_sys_rst)
		(i_single_session_fuse && o_map_write_lock) |=> o_map_write_lock
	) else $error("lock cleared while fuse set");

	chk_null_not_routed: assert property (
		disable iff (i_sys_rst)
		(route_act & null_mask) == '0
	) else $error("null code routed a peripheral output");

	chk_route_beats_gpio: assert property (
		disable iff (i_sys_rst)
		((o_pin_out ^ route_val) & route_act & ~i_analog_en) == '0 &&
			((~o_pin_oe) & route_act & ~i_analog_en) == '0
	) else $error("routed output did not win the pin");

	chk_analog_no_drive: assert property (
		disable iff (i_sys_rst)
		(o_pin_oe & i_analog_en) == '0
	) else $error("analog pin driven digitally");

	chk_absent_pin_idle: assert property (
		disable iff (i_sys_rst)
		((o_periph_in ^ IDLE_LEVEL) & absent_mask) == '0
	) else $error("absent pin did not give idle level");

	chk_armed_after_key: assert property (
		disable iff (i_sys_rst)
		s_key_first ##1 s_key_second |=> o_unlock_armed
	) else $error("key sequence did not arm the lock write");

	chk_lock_set_lands: assert property (
		disable iff (i_sys_rst)
		s_key_first ##1 s_key_second ##1 s_lock_set |=> o_map_write_lock
	) else $error("lock not set after full key sequence");

	chk_sel_wr_disarms: assert property (
		disable iff (i_sys_rst)
		(armed && any_sel_wr) |=> !o_unlock_armed
	) else $error("selector write left the lock armed");

endmodule : remappable_peripheral_pin_select

`default_nettype wire

// [test/periph_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"

// ----------------------------------------------------------------------
// far side: peripherals and external pins
// ----------------------------------------------------------------------
module periph_pin_model (
	input  wire logic                     i_clk,        // bench clock
	output logic      [`PPS_PERIPH_W-1:0] o_periph_out, // peripheral outputs by code
	output logic      [`PPS_NUM_PINS-1:0] o_pin_lvl     // levels seen on the pins
);
	// pattern source; it moves every cycle so a stale or pipelined route shows
	logic [31:0] pattern = 32'h5a3c_96e1;

	// shift register advances on every rising edge
	always_ff @(posedge i_clk) begin
		pattern <= {pattern[30:0], pattern[31] ^ pattern[21] ^ pattern[1] ^ pattern[0]};
	end

	// peripherals only present levels by function code, never on a pin of their own
	assign o_periph_out = pattern ^ 32'h0f0f_3c3c;
	// unused codes toggle too, so a wrong select cannot hide behind a quiet bit
	assign o_pin_lvl    = pattern[31:10] ^ pattern[21:0];
endmodule : periph_pin_model
`default_nettype wire

// [test/remappable_peripheral_pin_select_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"

module remappable_peripheral_pin_select_tb;
	// ------------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------------
	logic                       clk = 1'b0;   // 10 MHz clock
	logic                       sys_rst;      // sync reset
	logic                       fuse;         // single session fuse
	logic                       key_wr;       // key write pulse
	logic [7:0]                 key_data;     // key byte
	logic                       lock_wr;      // lock write pulse
	logic                       lock_data;    // lock value
	logic                       in_sel_wr;    // input selector write
	logic [`PPS_SEL_W-1:0]      in_sel_idx;   // input index
	logic                       out_sel_wr;   // output selector write
	logic [`PPS_SEL_W-1:0]      out_sel_idx;  // pin index
	logic [`PPS_SEL_W-1:0]      sel_data;     // selector value
	logic [`PPS_SEL_W-1:0]      rd_idx;       // readback index
	logic [`PPS_NUM_PINS-1:0]   gpio_out;     // fixed function data
	logic [`PPS_NUM_PINS-1:0]   gpio_oe;      // fixed function enable
	logic [`PPS_NUM_PINS-1:0]   analog_en;    // analog mode per pin
	logic [`PPS_NUM_PINS-1:0]   pin_lvl;      // from the far side model
	logic [`PPS_PERIPH_W-1:0]   periph_out;   // from the far side model
	logic [`PPS_NUM_INPUTS-1:0] periph_in;    // routed inputs
	logic [`PPS_NUM_PINS-1:0]   pin_out;      // pin level
	logic [`PPS_NUM_PINS-1:0]   pin_oe;       // pin driven
	logic                       map_lock;     // lock state
	logic                       armed;        // unlock armed
	logic [`PPS_SEL_W-1:0]      in_rdata;     // input readback
	logic [`PPS_SEL_W-1:0]      out_rdata;    // output readback
	int                         fails;        // mismatches
	int                         samples_checked; // comparisons

	// ------------------------------------------------------------------
	// clock, design and far side
	// ------------------------------------------------------------------
	always #50 clk = ~clk;

	remappable_peripheral_pin_select i_dut (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_single_session_fuse(fuse),
		.i_key_wr(key_wr), .i_key_data(key_data), .i_lock_wr(lock_wr),
		.i_lock_data(lock_data), .i_in_sel_wr(in_sel_wr), .i_in_sel_idx(in_sel_idx),
		.i_out_sel_wr(out_sel_wr), .i_out_sel_idx(out_sel_idx), .i_sel_data(sel_data),
		.i_rd_idx(rd_idx), .i_pin_in(pin_lvl), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe),
		.i_analog_en(analog_en), .i_periph_out(periph_out), .o_periph_in(periph_in),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_map_write_lock(map_lock),
		.o_unlock_armed(armed), .o_in_sel_rdata(in_rdata), .o_out_sel_rdata(out_rdata));

	periph_pin_model i_far (.i_clk(clk), .o_periph_out(periph_out), .o_pin_lvl(pin_lvl));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// each write task ends on the edge that takes the write
	task automatic wr_out(input int pin, input int code);
		@(posedge clk);
		out_sel_idx <= 5'(pin);
		sel_data    <= 5'(code);
		out_sel_wr  <= 1'b1;
		@(posedge clk);
		out_sel_wr  <= 1'b0;
	endtask : wr_out

	task automatic wr_in(input int idx, input int pin);
		@(posedge clk);
		in_sel_idx <= 5'(idx);
		sel_data   <= 5'(pin);
		in_sel_wr  <= 1'b1;
		@(posedge clk);
		in_sel_wr  <= 1'b0;
	endtask : wr_in

	task automatic key(input logic [7:0] b);
		@(posedge clk);
		key_data <= b;
		key_wr   <= 1'b1;
		@(posedge clk);
		key_wr   <= 1'b0;
	endtask : key

	task automatic lock(input logic v);
		@(posedge clk);
		lock_data <= v;
		lock_wr   <= 1'b1;
		@(posedge clk);
		lock_wr   <= 1'b0;
	endtask : lock

	// 55h, AAh and the lock write on three edges in a row
	task automatic unlock(input logic v);
		@(posedge clk);
		key_data <= `PPS_KEY_FIRST;
		key_wr   <= 1'b1;
		@(posedge clk);
		key_data <= `PPS_KEY_SECOND;
		@(posedge clk);
		key_wr    <= 1'b0;
		lock_data <= v;
		lock_wr   <= 1'b1;
		@(posedge clk);
		lock_wr   <= 1'b0;
	endtask : unlock

	// readback is registered, so one extra edge passes before sampling
	task automatic rd(input int idx);
		@(posedge clk);
		rd_idx <= 5'(idx);
		@(posedge clk);
		@(negedge clk);
	endtask : rd

	task automatic do_reset;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
	endtask : do_reset

	function automatic logic is_code(input int c);
		return (c >= 1 && c <= 3) || c == 6 || c == 7 || (c >= 10 && c <= 25);
	endfunction : is_code

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_state;
		for (int i = 0; i < `PPS_NUM_INPUTS; i++) begin
			rd(i);
			check("in sel reset", 5'h1f, in_rdata);
		end
		for (int p = 0; p < `PPS_NUM_PINS; p++) begin
			rd(p);
			check("out sel reset", 5'h00, out_rdata);
		end
		check("inputs idle", 18'h1_0000, periph_in);
		check("pin oe reset", gpio_oe, pin_oe);
		check("pin out reset", gpio_out, pin_out);
		check("lock reset", 1'b0, map_lock);
	endtask : t_reset_state

	// every code 0..31 onto a pin; the fixed function drives where no route exists
	task automatic t_out_codes;
		int p;
		for (int c = 0; c < 32; c++) begin
			p = c % `PPS_NUM_PINS;
			wr_out(p, c);
			for (int k = 0; k < 2; k++) begin
				@(negedge clk);
				check("pin oe", is_code(c) ? 1'b1 : gpio_oe[p], pin_oe[p]);
				check("pin out", is_code(c) ? periph_out[c] : gpio_out[p], pin_out[p]);
			end
		end
	endtask : t_out_codes

	// one output on several pins, one pin into several inputs, absent pins
	task automatic t_fanout;
		wr_out(2, 11);
		wr_out(21, 11);
		@(negedge clk);
		check("fan pin 2", periph_out[11], pin_out[2]);
		check("fan pin 21", periph_out[11], pin_out[21]);
		for (int i = 0; i < `PPS_NUM_INPUTS; i++) wr_in(i, 21 - i);
		@(negedge clk);
		for (int i = 0; i < `PPS_NUM_INPUTS; i++)
			check("input route", pin_lvl[21 - i], periph_in[i]);
		wr_in(7, 21);
		@(negedge clk);
		check("fan input 7", pin_lvl[21], periph_in[7]);
		check("fan input 0", pin_lvl[21], periph_in[0]);
		wr_in(16, 22);
		wr_in(0, 31);
		@(negedge clk);
		check("absent select", 1'b1, periph_in[16]);
		check("absent int", 1'b0, periph_in[0]);
	endtask : t_fanout

	// analog mode wins over a routed output and input
	task automatic t_analog;
		wr_out(5, 14);
		wr_in(3, 5);
		@(posedge clk);
		analog_en <= 22'h00_0020;
		@(negedge clk);
		check("analog oe", 1'b0, pin_oe[5]);
		check("analog out", 1'b0, pin_out[5]);
		check("analog in", 1'b0, periph_in[3]);
		@(posedge clk);
		analog_en <= '0;
	endtask : t_analog

	task automatic t_lock;
		lock(1'b1);
		@(negedge clk);
		check("lock no key", 1'b0, map_lock);
		key(8'h55);
		key(8'h12);
		key(8'haa);
		lock(1'b1);
		@(negedge clk);
		check("lock bad key", 1'b0, map_lock);
		key(8'h55);
		key(8'haa);
		wr_in(3, 5);
		lock(1'b1);
		@(negedge clk);
		check("lock after sel write", 1'b0, map_lock);
		key(8'h55);
		key(8'haa);
		@(negedge clk);
		check("armed", 1'b1, armed);
		lock(1'b1);
		@(negedge clk);
		check("locked", 1'b1, map_lock);
		wr_out(5, 6);
		wr_in(3, 9);
		rd(5);
		check("locked out sel", 5'h0e, out_rdata);
		check("locked route", periph_out[14], pin_out[5]);
		rd(3);
		check("locked in sel", 5'h05, in_rdata);
		unlock(1'b0);
		@(negedge clk);
		check("unlocked", 1'b0, map_lock);
		@(posedge clk);
		fuse <= 1'b1;
		unlock(1'b1);
		@(negedge clk);
		check("fuse sets lock", 1'b1, map_lock);
		unlock(1'b0);
		@(negedge clk);
		check("fuse holds lock", 1'b1, map_lock);
		do_reset();
		@(negedge clk);
		check("lock after reset", 1'b0, map_lock);
	endtask : t_lock

	// ------------------------------------------------------------------
	// verdict and main sequence
	// ------------------------------------------------------------------
	task automatic report_and_stop;
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial begin
		// reset high from time zero, so no check sees unset flops
		sys_rst = 1'b1;
		{fuse, key_wr, lock_wr, lock_data, in_sel_wr, out_sel_wr} = '0;
		{key_data, in_sel_idx, out_sel_idx, sel_data, rd_idx, analog_en} = '0;
		gpio_out = 22'h0f_0f0f;
		gpio_oe  = 22'h15_5555;
		fails = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset_state();
		t_out_codes();
		t_fanout();
		t_analog();
		t_lock();
		report_and_stop();
	end

	// the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule : remappable_peripheral_pin_select_tb
`default_nettype wire
